// *** logic/sssf_supervisor.sv ***
// Safe-state fault supervisor: mode, fault counter and refresh threshold control.
`timescale 1ns/1ns
`default_nettype none
`include "sssf_cfg.svh"

// Summary of operation
// - Supply undervoltage in SAFE by heat or pump: stay, count and threshold kept.
// - Refresh timer restarts from zero when the device returns to ACTIVE.
// - Heat in SAFE by supply: count up, LATCH at four, threshold 30 s.
// - Pump in SAFE by supply: count up, LATCH at four, threshold 100 ms.
// - Heat and pump in one SAFE stay: one count only, threshold 30 s.
// - Each SAFE fault is judged against the current cause; a counted fault in a supply stay becomes the cause.
// - From ACTIVE: supply goes SAFE uncounted; heat or pump count, LATCH next clock at four.

module sssf_supervisor
  import sssf_pkg::*;
#(
  parameter logic [`SSSF_TMR_W-1:0] REFRESH_LONG_CYC =
    32'(64'(`SSSF_REFRESH_LONG_S) * 64'(`SSSF_CLK_HZ)),
  parameter logic [`SSSF_TMR_W-1:0] REFRESH_SHORT_CYC =
    32'(64'(`SSSF_REFRESH_SHORT_MS) * 64'(`SSSF_CLK_HZ) / 64'd1000)
) (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        ce_i,
  input  wire logic                        supply_uv_i,
  input  wire logic                        overtemp_i,
  input  wire logic                        charge_pump_uv_i,
  input  wire logic                        safe_exit_i,
  output var sssf_status_type              status_o
);

  // ========================================================================
  // Fault detector synchronisers and edge detection
  // ========================================================================
  logic [`SSSF_FAULT_NUM-1:0] fault_raw;
  logic [`SSSF_FAULT_NUM-1:0] sync1_r;
  logic [`SSSF_FAULT_NUM-1:0] sync2_r;
  logic [`SSSF_FAULT_NUM-1:0] prev_r;
  logic [`SSSF_FAULT_NUM-1:0] fault_evt;

  assign fault_raw[`SSSF_FAULT_SUPPLY]   = supply_uv_i;
  assign fault_raw[`SSSF_FAULT_OVERTEMP] = overtemp_i;
  assign fault_raw[`SSSF_FAULT_CPUMP]    = charge_pump_uv_i;

  // Each detector passes two flops; only the second one feeds the edge detector.
  genvar gi;
  generate
    for (gi = 0; gi < `SSSF_FAULT_NUM; gi = gi + 1) begin : g_sync
      logic s1_nxt;
      logic s2_nxt;
      logic pv_nxt;

      // Next values of the synchroniser stages and the edge history.
      always_comb begin
        s1_nxt = fault_raw[gi];
        s2_nxt = sync1_r[gi];
        pv_nxt = sync2_r[gi];
      end

      // Registers the stages; the clock enable freezes them too.
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi]  <= 1'b0;
        end else if (ce_i) begin
          sync1_r[gi] <= s1_nxt;
          sync2_r[gi] <= s2_nxt;
          prev_r[gi]  <= pv_nxt;
        end
      end

      assign fault_evt[gi] = sync2_r[gi] & ~prev_r[gi];
    end
  endgenerate

  logic evt_supply;
  logic evt_ot;
  logic evt_cp;

  assign evt_supply = fault_evt[`SSSF_FAULT_SUPPLY];
  assign evt_ot     = fault_evt[`SSSF_FAULT_OVERTEMP];
  assign evt_cp     = fault_evt[`SSSF_FAULT_CPUMP];

  // ========================================================================
  // Refresh timer
  // ========================================================================
  logic                   tmr_hit;
  logic                   tmr_run;
  logic                   tmr_clr;
  logic [`SSSF_TMR_W-1:0] tmr_limit;

  sssf_mode_type          mode_r;
  sssf_mode_type          mode_nxt;
  sssf_cause_type         cause_r;
  sssf_cause_type         cause_nxt;
  logic [`SSSF_CNT_W-1:0] cnt_r;
  logic [`SSSF_CNT_W-1:0] cnt_nxt;
  logic                   thr_long_r;
  logic                   thr_long_nxt;
  logic                   pend_r;
  logic                   pend_nxt;
  logic                   both_r;
  logic                   both_nxt;
  logic                   any_evt;

  assign any_evt = evt_supply | evt_ot | evt_cp;

  // The timer runs only in ACTIVE with a count to refresh; it is held at
  // zero in any other mode, so each return to ACTIVE starts it from zero.
  assign tmr_run   = (mode_r == SSSF_ACTIVE) && (cnt_r != `SSSF_CNT_RST) && !any_evt;
  assign tmr_clr   = (mode_r != SSSF_ACTIVE) || any_evt;
  assign tmr_limit = thr_long_r ? REFRESH_LONG_CYC : REFRESH_SHORT_CYC;

  sssf_refresh_timer u_timer (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .run_i   (tmr_run),
    .clr_i   (tmr_clr),
    .limit_i (tmr_limit),
    .hit_o   (tmr_hit)
  );

  // ========================================================================
  // Mode, cause, counter and threshold control
  // ========================================================================
  // Heat is served before pump, and pump before supply, when they coincide.
  always_comb begin
    mode_nxt     = mode_r;
    cause_nxt    = cause_r;
    cnt_nxt      = cnt_r;
    thr_long_nxt = thr_long_r;
    pend_nxt     = 1'b0;
    both_nxt     = both_r;
    unique case (mode_r)
      SSSF_ACTIVE: begin
        if (evt_ot || evt_cp) begin
          // A counted fault: enter SAFE, LATCH one clock later at four.
          mode_nxt     = SSSF_SAFE;
          cause_nxt    = evt_ot ? SSSF_CAUSE_OT : SSSF_CAUSE_CP;
          cnt_nxt      = cnt_r + 3'h1;
          thr_long_nxt = evt_ot;
          pend_nxt     = (cnt_r + 3'h1 == `SSSF_CNT_LATCH);
          both_nxt     = evt_ot && evt_cp;
        end else if (evt_supply) begin
          // Supply loss enters SAFE uncounted; the threshold is kept.
          mode_nxt  = SSSF_SAFE;
          cause_nxt = SSSF_CAUSE_SUPPLY;
          both_nxt  = 1'b0;
          if (cnt_r == `SSSF_CNT_RST) begin
            thr_long_nxt = `SSSF_THR_LONG_RST;
          end
        end else if (tmr_hit) begin
          cnt_nxt      = `SSSF_CNT_RST;
          thr_long_nxt = `SSSF_THR_LONG_RST;
        end
      end
      SSSF_SAFE: begin
        if (pend_r) begin
          mode_nxt = SSSF_LATCH;
        end else if (cause_r == SSSF_CAUSE_SUPPLY && (evt_ot || evt_cp)) begin
          // A counted fault on top of a supply SAFE stay.
          cnt_nxt      = cnt_r + 3'h1;
          cause_nxt    = evt_ot ? SSSF_CAUSE_OT : SSSF_CAUSE_CP;
          thr_long_nxt = evt_ot;
          both_nxt     = evt_ot && evt_cp;
          if (cnt_r + 3'h1 == `SSSF_CNT_LATCH) begin
            mode_nxt = SSSF_LATCH;
          end
        end else if (!both_r && ((cause_r == SSSF_CAUSE_OT && evt_cp) ||
                                 (cause_r == SSSF_CAUSE_CP && evt_ot))) begin
          // The second of heat and pump: already counted once this stay.
          // Once both have been seen the stay is settled at the long threshold.
          thr_long_nxt = 1'b1;
          both_nxt     = 1'b1;
        end else if (cause_r != SSSF_CAUSE_SUPPLY && evt_supply) begin
          // Supply loss during a heat or pump stay changes nothing.
          cnt_nxt      = cnt_r;
          thr_long_nxt = thr_long_r;
        end else if (safe_exit_i && !any_evt) begin
          // Back to ACTIVE; the timer restarts from zero there.
          mode_nxt  = SSSF_ACTIVE;
          cause_nxt = SSSF_CAUSE_NONE;
          both_nxt  = 1'b0;
        end
      end
      SSSF_LATCH: begin
        mode_nxt = SSSF_LATCH;
      end
    endcase
  end

  // Registers the control state.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r     <= SSSF_ACTIVE;
      cause_r    <= SSSF_CAUSE_NONE;
      cnt_r      <= `SSSF_CNT_RST;
      thr_long_r <= `SSSF_THR_LONG_RST;
      pend_r     <= 1'b0;
      both_r     <= 1'b0;
    end else if (ce_i) begin
      mode_r     <= mode_nxt;
      cause_r    <= cause_nxt;
      cnt_r      <= cnt_nxt;
      thr_long_r <= thr_long_nxt;
      pend_r     <= pend_nxt;
      both_r     <= both_nxt;
    end
  end

  // ========================================================================
  // Status output
  // ========================================================================
  // The output fields are the control flops themselves.
  assign status_o.mode          = mode_r;
  assign status_o.cause         = cause_r;
  assign status_o.fault_counter = cnt_r;
  assign status_o.thr_long      = thr_long_r;
  assign status_o.latch_pending = pend_r;

endmodule
`default_nettype wire

// *** common/sssf_cfg.svh ***
// Constants of the safe-state fault supervisor: field positions, reset values and timing.
`ifndef SSSF_CFG_SVH
`define SSSF_CFG_SVH

// ==========================================================================
// Fault input positions
// ==========================================================================
`define SSSF_FAULT_NUM       3
`define SSSF_FAULT_SUPPLY    0
`define SSSF_FAULT_OVERTEMP  1
`define SSSF_FAULT_CPUMP     2

// ==========================================================================
// Counter limits and reset values
// ==========================================================================
`define SSSF_CNT_W           3
`define SSSF_CNT_LATCH       3'h4
`define SSSF_CNT_RST         3'h0
`define SSSF_THR_LONG_RST    1'b1

// ==========================================================================
// Timing
// ==========================================================================
`define SSSF_CLK_HZ          100000000
`define SSSF_REFRESH_LONG_S  30
`define SSSF_REFRESH_SHORT_MS 100
`define SSSF_TMR_W           32

`endif

// *** common/sssf_pkg.sv ***
// Types shared by the safe-state fault supervisor files.
package sssf_pkg;

  // ========================================================================
  // Operating modes, one-hot
  // ========================================================================
  typedef enum logic [2:0] {
    SSSF_ACTIVE = 3'h1,
    SSSF_SAFE   = 3'h2,
    SSSF_LATCH  = 3'h4
  } sssf_mode_type;

  // ========================================================================
  // Cause of the present SAFE stay, one-hot
  // ========================================================================
  typedef enum logic [3:0] {
    SSSF_CAUSE_NONE   = 4'h1,
    SSSF_CAUSE_SUPPLY = 4'h2,
    SSSF_CAUSE_OT     = 4'h4,
    SSSF_CAUSE_CP     = 4'h8
  } sssf_cause_type;

  // ========================================================================
  // Status carried to the outside
  // ========================================================================
  typedef struct packed {
    sssf_mode_type  mode;
    sssf_cause_type cause;
    logic [2:0]     fault_counter;
    logic           thr_long;
    logic           latch_pending;
  } sssf_status_type;

endpackage

// *** logic/sssf_refresh_timer.sv ***
// Fault-counter refresh timer with a selectable threshold.
`timescale 1ns/1ns
`default_nettype none
`include "sssf_cfg.svh"

module sssf_refresh_timer (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    ce_i,
  input  wire logic                    run_i,
  input  wire logic                    clr_i,
  input  wire logic [`SSSF_TMR_W-1:0]  limit_i,
  output logic                         hit_o
);

  logic [`SSSF_TMR_W-1:0] cnt_r;
  logic [`SSSF_TMR_W-1:0] cnt_nxt;
  logic                   hit_r;
  logic                   hit_nxt;

  // Counts while running; a clear always brings it back to zero.
  always_comb begin
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (clr_i) begin
      cnt_nxt = '0;
    end else if (run_i) begin
      if (cnt_r >= limit_i - 32'h1) begin
        hit_nxt = 1'b1;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
  end

  // Registers the count and the one-cycle hit pulse.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

endmodule
`default_nettype wire

// *** test/sssf_supervisor_monitor.sv ***
// Concurrent checks on the ports of the safe-state fault supervisor.
`timescale 1ns/1ns
`default_nettype none

module sssf_supervisor_monitor
  import sssf_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  input  wire logic            ce_i,
  input  wire logic            supply_uv_i,
  input  wire logic            overtemp_i,
  input  wire logic            charge_pump_uv_i,
  input  wire logic            safe_exit_i,
  input  wire sssf_status_type status_o
);
  // ========================================================================
  // Views of the status fields
  // ========================================================================
  sssf_mode_type  md;
  sssf_cause_type cs;
  logic [2:0]     cnt;
  logic           quiet;
  // Splits the status word and marks enabled cycles with no fault pin raised.
  assign md    = status_o.mode;
  assign cs    = status_o.cause;
  assign cnt   = status_o.fault_counter;
  assign quiet = ce_i && !supply_uv_i && !overtemp_i && !charge_pump_uv_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ========================================================================
  // Assertions
  // ========================================================================
  AST_LATCH_HOLDS: assert property (md == SSSF_LATCH |=> md == SSSF_LATCH)
    else $error("latch mode was left");
  AST_PENDING_NEXT: assert property ((status_o.latch_pending && ce_i) |=>
    (md == SSSF_LATCH && !status_o.latch_pending)) else $error("pending latch not taken");
  AST_LATCH_AT_FOUR: assert property ((md == SSSF_LATCH && $past(md) != SSSF_LATCH)
    |-> cnt == 3'h4) else $error("latch entered at a count other than four");
  AST_CNT_STEP: assert property ($changed(cnt) |->
    (cnt == $past(cnt) + 3'h1 || cnt == 3'h0)) else $error("counter moved by a wrong step");
  AST_SAFE_NO_RECOUNT: assert property ((md == SSSF_SAFE &&
    (cs == SSSF_CAUSE_OT || cs == SSSF_CAUSE_CP)) |=> (md != SSSF_SAFE || $stable(cnt)))
    else $error("counter moved during a heat or pump stay");
  AST_OT_LONG: assert property ((md == SSSF_SAFE && cs == SSSF_CAUSE_OT) |->
    status_o.thr_long) else $error("heat stay without the long threshold");
  AST_EXIT: assert property (quiet [*4] ##0 (md == SSSF_SAFE && safe_exit_i &&
    !status_o.latch_pending) |=> (md == SSSF_ACTIVE && cs == SSSF_CAUSE_NONE))
    else $error("safe exit not taken");
  AST_ACTIVE_NONE: assert property (md == SSSF_ACTIVE |-> cs == SSSF_CAUSE_NONE)
    else $error("cause shown while active");
  AST_CLEAR: assert property (($past(cnt) != 3'h0 && cnt == 3'h0) |->
    (md == SSSF_ACTIVE && status_o.thr_long)) else $error("counter cleared wrongly");
  AST_COUNT_CAUSE: assert property ((cnt == $past(cnt) + 3'h1 && cnt != 3'h0) |->
    ($past(overtemp_i, 2) || $past(overtemp_i, 3) || $past(charge_pump_uv_i, 2) ||
    $past(charge_pump_uv_i, 3))) else $error("count without heat or pump fault");

  // Main scenarios reached.
  COV_LATCH: cover property (md == SSSF_LATCH);
  COV_CLEAR: cover property ($past(cnt) != 3'h0 && cnt == 3'h0);
  COV_OT_STAY: cover property (md == SSSF_SAFE && cs == SSSF_CAUSE_OT);
endmodule

bind sssf_supervisor sssf_supervisor_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .supply_uv_i(supply_uv_i), .overtemp_i(overtemp_i),
  .charge_pump_uv_i(charge_pump_uv_i), .safe_exit_i(safe_exit_i), .status_o(status_o));
`default_nettype wire

// *** test/sssf_detector_model.sv ***
// Behavioural model of the supply, heat and pump fault detectors.
`timescale 1ns/1ns
`default_nettype none

module sssf_detector_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] fire_i,
  output var logic  [2:0] flt_o
);
  int unsigned left [3];
  // A fired detector holds its level for four clocks, then drops it.
  initial flt_o = 3'h0;
  always @(negedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (fire_i[k]) left[k] = 4;
      else if (left[k] != 0) left[k] = left[k] - 1;
      flt_o[k] = (left[k] != 0);
    end
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking testbench of the safe-state fault supervisor.
`timescale 1ns/1ns
`default_nettype none
`include "sssf_cfg.svh"

module testbench
  import sssf_pkg::*;
;
  localparam logic [2:0] S = 3'h1;
  localparam logic [2:0] O = 3'h2;
  localparam logic [2:0] C = 3'h4;
  logic            clk_i;
  logic            nrst_i;
  logic            ce_i;
  logic            safe_exit_i;
  logic [2:0]      fire;
  logic [2:0]      flt;
  sssf_status_type st;
  int              mismatches;
  int              tests_run;
  int              cycles;

  // Short refresh limits keep the run brief: 40 long and 10 short.
  sssf_supervisor #(.REFRESH_LONG_CYC(32'h28), .REFRESH_SHORT_CYC(32'ha)) uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .supply_uv_i(flt[`SSSF_FAULT_SUPPLY]), .overtemp_i(flt[`SSSF_FAULT_OVERTEMP]),
    .charge_pump_uv_i(flt[`SSSF_FAULT_CPUMP]), .safe_exit_i(safe_exit_i), .status_o(st));
  sssf_detector_model u_det (.clk_i(clk_i), .fire_i(fire), .flt_o(flt));

  // Clock and hang guard.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: run took too long", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    nrst_i <= 1'b0;
    repeat (20) @(negedge clk_i);
    nrst_i <= 1'b1;
  endtask

  // Fires one detector and waits until the status has settled.
  task automatic fault(input logic [2:0] m);
    @(negedge clk_i);
    fire <= m;
    @(negedge clk_i);
    fire <= 3'h0;
    repeat (6) @(negedge clk_i);
  endtask

  task automatic leave();
    @(negedge clk_i);
    safe_exit_i <= 1'b1;
    @(negedge clk_i);
    safe_exit_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic chk(input sssf_mode_type m, input logic [2:0] n, input logic t, input string w);
    tests_run++;
    if (st.mode !== m || st.fault_counter !== n || st.thr_long !== t) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, w);
    end
  endtask

  // Supply stay, then heat, pump and supply again; timer restart on return.
  task automatic t_supply_stay();
    do_reset();
    fault(S);
    chk(SSSF_SAFE, 3'h0, 1'b1, "supply from active");
    fault(O);
    chk(SSSF_SAFE, 3'h1, 1'b1, "heat in supply stay");
    fault(C);
    chk(SSSF_SAFE, 3'h1, 1'b1, "pump after heat");
    fault(S);
    chk(SSSF_SAFE, 3'h1, 1'b1, "supply in heat stay");
    leave();
    wait_n(30);
    fault(S);
    leave();
    wait_n(30);
    chk(SSSF_ACTIVE, 3'h1, 1'b1, "timer not restarted");
    wait_n(15);
    chk(SSSF_ACTIVE, 3'h0, 1'b1, "long refresh clear");
  endtask

  // Pump stay with supply, short refresh, then heat during pump stay.
  task automatic t_pump_stay();
    do_reset();
    fault(C);
    chk(SSSF_SAFE, 3'h1, 1'b0, "pump from active");
    fault(S);
    chk(SSSF_SAFE, 3'h1, 1'b0, "supply in pump stay");
    leave();
    wait_n(5);
    chk(SSSF_ACTIVE, 3'h1, 1'b0, "short refresh too early");
    // A low clock enable must freeze the refresh timer and the counter.
    ce_i <= 1'b0;
    wait_n(20);
    chk(SSSF_ACTIVE, 3'h1, 1'b0, "clock enable did not freeze");
    ce_i <= 1'b1;
    wait_n(10);
    chk(SSSF_ACTIVE, 3'h0, 1'b1, "short refresh clear");
    fault(C);
    fault(O);
    chk(SSSF_SAFE, 3'h1, 1'b1, "heat after pump");
  endtask

  // Count of three, then a supply stay and a counted fault reaching four.
  task automatic t_latch_safe(input logic [2:0] m, input logic t);
    do_reset();
    repeat (3) begin
      fault(O);
      leave();
    end
    chk(SSSF_ACTIVE, 3'h3, 1'b1, "three counted faults");
    fault(S);
    fault(m);
    chk(SSSF_LATCH, 3'h4, t, "fourth fault in supply stay");
    fault(O);
    leave();
    chk(SSSF_LATCH, 3'h4, t, "latch left");
  endtask

  task automatic t_latch_active();
    do_reset();
    repeat (3) begin
      fault(C);
      leave();
    end
    fault(O);
    chk(SSSF_LATCH, 3'h4, 1'b1, "fourth fault from active");
  endtask

  // Main sequence.
  initial begin
    nrst_i      = 1'b0;
    ce_i        = 1'b1;
    safe_exit_i = 1'b0;
    fire        = 3'h0;
    mismatches  = 0;
    tests_run   = 0;
    cycles      = 0;
    t_supply_stay();
    t_pump_stay();
    t_latch_safe(O, 1'b1);
    t_latch_safe(C, 1'b0);
    t_latch_active();
    finish_test();
  end
endmodule
`default_nettype wire
